// ---- design/power_good_output_mask_bank.sv ----
// Power-good mask registers, APB slave and output pin trees
`timescale 1ns/10ps

//
// Behaviour
// - Mask bit 7 clear includes second linear regulator
// - Any mask bit set drops its source
// - Bit 6 gates load switch A one
// - Bits 5..0 gate step-down rails six..one
// - Second bits 7..4 gate control inputs
// - Second bit 3 gates termination regulator
// - Second bit 2 gates variant-chosen shared source
// - Second bit 1 gates load switch B one
// - Second bit 0 gates third linear regulator
// - Pin-two masks at indices a8h, a9h
// - Pin-three first mask at aah, same layout
module power_good_output_mask_bank #(
  parameter int unsigned ADDR_WIDTH = 10,
  parameter int unsigned VARIANT = 0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [5:0] step_down_good_i,
  input wire logic second_adjustable_linear_reg_good_i,
  input wire logic third_adjustable_linear_reg_good_i,
  input wire logic load_switch_a_one_good_i,
  input wire logic load_switch_b_one_good_i,
  input wire logic switch_b_two_good_i,
  input wire logic first_adjustable_linear_reg_good_i,
  input wire logic memory_termination_reg_good_i,
  input wire logic control_input_one_i,
  input wire logic control_input_two_i,
  input wire logic control_input_four_i,
  input wire logic control_input_five_i,
  output logic general_output_pin_two_o,
  output logic general_output_pin_three_o
);
  import pg_mask_pkg::*;

  typedef enum {
    SEL_NONE,
    SEL_PIN2_FIRST,
    SEL_PIN2_SECOND,
    SEL_PIN3_FIRST,
    SEL_STATUS
  } reg_sel_type;

  logic [MASK_WIDTH-1:0] pin2_rail_mask_first_reg;
  logic [MASK_WIDTH-1:0] pin2_rail_mask_second_reg;
  logic [MASK_WIDTH-1:0] pin3_rail_mask_first_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;
  logic setup_phase;
  logic write_done;
  logic lane0_write;
  reg_sel_type setup_sel;
  reg_sel_type access_sel;

  logic [MASK_WIDTH-1:0] first_group_good;
  logic [MASK_WIDTH-1:0] second_group_good;
  logic [MASK_WIDTH-1:0] first_group_reg;
  logic [MASK_WIDTH-1:0] second_group_reg;
  logic shared_source_good;
  logic [PIN2_SOURCES-1:0] pin2_mask_vec;
  logic [PIN2_SOURCES-1:0] pin2_good_vec;
  logic [PIN2_SOURCES-1:0] pin2_fail;
  logic [PIN3_SOURCES-1:0] pin3_fail;
  logic pin2_level;
  logic pin3_level;

  generate
    if (ADDR_WIDTH < MIN_ADDR_WIDTH) begin : g_addr_check
      $error("ADDR_WIDTH too small to reach every register");
    end
    if (VARIANT >= VARIANT_COUNT) begin : g_variant_check
      $error("VARIANT outside the factory variant range");
    end
  endgenerate

  // Full decode: upper address bits and byte offset must be zero
  function automatic reg_sel_type decode_addr(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] base;
    base = addr;
    decode_addr = SEL_NONE;
    if (base[IDX_LSB-1:0] == 2'b00 && (base >> (IDX_LSB + 8)) == '0) begin
      case (base[IDX_LSB +: 8])
        IDX_PIN2_FIRST: decode_addr = SEL_PIN2_FIRST;
        IDX_PIN2_SECOND: decode_addr = SEL_PIN2_SECOND;
        IDX_PIN3_FIRST: decode_addr = SEL_PIN3_FIRST;
        IDX_STATUS: decode_addr = SEL_STATUS;
        default: decode_addr = SEL_NONE;
      endcase
    end
  endfunction

  // Bus control
  always_comb begin
    setup_phase = psel_i && !penable_i;
    setup_sel = decode_addr(paddr_i);
    access_sel = decode_addr(paddr_i);
    write_done = psel_i && penable_i && pready_reg && pwrite_i;
    lane0_write = write_done && pstrb_i[0];
  end

  // One wait-free access cycle: answer is prepared during the setup cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Unmapped addresses and writes to the read-only status word are errors
  always_comb begin
    pslverr_next = 1'b0;
    case (setup_sel)
      SEL_NONE: pslverr_next = 1'b1;
      SEL_STATUS: pslverr_next = pwrite_i;
      default: pslverr_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= pslverr_next;
    end else if (pready_reg) begin
      pslverr_reg <= 1'b0;
    end
  end

  // Read data, narrow masks in the low byte with upper bits zero; the status word fills bits 25..0
  always_comb begin
    prdata_next = READ_ZERO;
    case (setup_sel)
      SEL_PIN2_FIRST: prdata_next[MASK_WIDTH-1:0] = pin2_rail_mask_first_reg;
      SEL_PIN2_SECOND: prdata_next[MASK_WIDTH-1:0] = pin2_rail_mask_second_reg;
      SEL_PIN3_FIRST: prdata_next[MASK_WIDTH-1:0] = pin3_rail_mask_first_reg;
      SEL_STATUS: begin
        prdata_next[STAT_PIN2_FAIL_LSB +: PIN2_SOURCES] = pin2_fail;
        prdata_next[STAT_PIN3_FAIL_LSB +: PIN3_SOURCES] = pin3_fail;
        prdata_next[STAT_PIN2_LEVEL] = pin2_level;
        prdata_next[STAT_PIN3_LEVEL] = pin3_level;
      end
      default: prdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_reg <= READ_ZERO;
    end else if (setup_phase && !pwrite_i) begin
      prdata_reg <= prdata_next;
    end else if (pready_reg) begin
      prdata_reg <= READ_ZERO;
    end
  end

  // Mask registers: factory defaults at reset, byte lane 0 on write
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin2_rail_mask_first_reg <= PIN2_FIRST_DEFAULT[VARIANT];
    end else if (lane0_write && access_sel == SEL_PIN2_FIRST) begin
      pin2_rail_mask_first_reg <= pwdata_i[MASK_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin2_rail_mask_second_reg <= PIN2_SECOND_DEFAULT[VARIANT];
    end else if (lane0_write && access_sel == SEL_PIN2_SECOND) begin
      pin2_rail_mask_second_reg <= pwdata_i[MASK_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin3_rail_mask_first_reg <= PIN3_FIRST_DEFAULT[VARIANT];
    end else if (lane0_write && access_sel == SEL_PIN3_FIRST) begin
      pin3_rail_mask_first_reg <= pwdata_i[MASK_WIDTH-1:0];
    end
  end

  // Shared source is fixed by the factory variant, not by software
  always_comb begin
    if (VARIANT == VARIANT_SHARED_SWITCH) begin
      shared_source_good = switch_b_two_good_i;
    end else begin
      shared_source_good = first_adjustable_linear_reg_good_i;
    end
  end

  // First group in mask bit order
  always_comb begin
    first_group_good = '0;
    first_group_good[BIT_SECOND_LINEAR] = second_adjustable_linear_reg_good_i;
    first_group_good[BIT_SWITCH_A_ONE] = load_switch_a_one_good_i;
    first_group_good[BIT_STEP_DOWN_SIX:BIT_STEP_DOWN_ONE] = step_down_good_i;
  end

  // Second group; control inputs count as good when high
  always_comb begin
    second_group_good = '0;
    second_group_good[BIT_CONTROL_FIVE] = control_input_five_i;
    second_group_good[BIT_CONTROL_FOUR] = control_input_four_i;
    second_group_good[BIT_CONTROL_TWO] = control_input_two_i;
    second_group_good[BIT_CONTROL_ONE] = control_input_one_i;
    second_group_good[BIT_TERMINATION] = memory_termination_reg_good_i;
    second_group_good[BIT_SHARED] = shared_source_good;
    second_group_good[BIT_SWITCH_B_ONE] = load_switch_b_one_good_i;
    second_group_good[BIT_THIRD_LINEAR] = third_adjustable_linear_reg_good_i;
  end

  // Capture all sources on one edge so both trees see a coherent snapshot
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_group_reg <= '0;
    end else begin
      first_group_reg <= first_group_good;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      second_group_reg <= '0;
    end else begin
      second_group_reg <= second_group_good;
    end
  end

  always_comb begin
    pin2_good_vec = {second_group_reg, first_group_reg};
    pin2_mask_vec = {pin2_rail_mask_second_reg, pin2_rail_mask_first_reg};
  end

  // Pin two: all sixteen sources, masked bits ignored
  pg_tree #(
    .WIDTH(PIN2_SOURCES)
  ) u_pin2_tree (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .good_i(pin2_good_vec),
    .mask_i(pin2_mask_vec),
    .level_o(pin2_level),
    .fail_o(pin2_fail)
  );

  // Pin three: only the first group is masked here; the rest is not in this bank
  pg_tree #(
    .WIDTH(PIN3_SOURCES)
  ) u_pin3_tree (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .good_i(first_group_reg),
    .mask_i(pin3_rail_mask_first_reg),
    .level_o(pin3_level),
    .fail_o(pin3_fail)
  );

  // Pins are re-registered so they come straight from flip-flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      general_output_pin_two_o <= PG_LEVEL_RESET;
    end else begin
      general_output_pin_two_o <= pin2_level;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      general_output_pin_three_o <= PG_LEVEL_RESET;
    end else begin
      general_output_pin_three_o <= pin3_level;
    end
  end

  always_comb begin
    prdata_o = prdata_reg;
    pready_o = pready_reg;
    pslverr_o = pslverr_reg;
  end

endmodule

// ---- shared/pg_mask_pkg.sv ----
// Shared constants for the power-good output mask bank
package pg_mask_pkg;

  // Register indices; each register is one aligned 32-bit word at index * 4
  localparam logic [7:0] IDX_PIN2_FIRST = 8'ha8;
  localparam logic [7:0] IDX_PIN2_SECOND = 8'ha9;
  localparam logic [7:0] IDX_PIN3_FIRST = 8'haa;
  localparam logic [7:0] IDX_STATUS = 8'hc0;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned MIN_ADDR_WIDTH = 10;

  // First mask register layout (both pins)
  localparam int unsigned BIT_SECOND_LINEAR = 7;
  localparam int unsigned BIT_SWITCH_A_ONE = 6;
  localparam int unsigned BIT_STEP_DOWN_SIX = 5;
  localparam int unsigned BIT_STEP_DOWN_ONE = 0;
  localparam int unsigned STEP_DOWN_RAILS = 6;

  // Second mask register layout
  localparam int unsigned BIT_CONTROL_FIVE = 7;
  localparam int unsigned BIT_CONTROL_FOUR = 6;
  localparam int unsigned BIT_CONTROL_TWO = 5;
  localparam int unsigned BIT_CONTROL_ONE = 4;
  localparam int unsigned BIT_TERMINATION = 3;
  localparam int unsigned BIT_SHARED = 2;
  localparam int unsigned BIT_SWITCH_B_ONE = 1;
  localparam int unsigned BIT_THIRD_LINEAR = 0;

  localparam int unsigned MASK_WIDTH = 8;
  localparam int unsigned PIN2_SOURCES = 16;
  localparam int unsigned PIN3_SOURCES = 8;

  // Status register layout
  localparam int unsigned STAT_PIN2_FAIL_LSB = 0;
  localparam int unsigned STAT_PIN3_FAIL_LSB = 16;
  localparam int unsigned STAT_PIN2_LEVEL = 24;
  localparam int unsigned STAT_PIN3_LEVEL = 25;

  // Factory variants
  localparam int unsigned VARIANT_COUNT = 4;
  localparam int unsigned VARIANT_SHARED_SWITCH = 3;

  // Factory mask defaults, indexed by variant
  localparam logic [7:0] PIN2_FIRST_DEFAULT [VARIANT_COUNT] = '{8'hdf, 8'heb, 8'hdf, 8'hc0};
  localparam logic [7:0] PIN2_SECOND_DEFAULT [VARIANT_COUNT] = '{8'h3f, 8'hfc, 8'hff, 8'hc7};
  localparam logic [7:0] PIN3_FIRST_DEFAULT [VARIANT_COUNT] = '{8'he0, 8'h5c, 8'hf7, 8'hdf};

  localparam logic PG_LEVEL_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ---- design/pg_tree.sv ----
// Masked power-good combiner for one output pin
`timescale 1ns/10ps
module pg_tree #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] good_i,
  input wire logic [WIDTH-1:0] mask_i,
  output logic level_o,
  output logic [WIDTH-1:0] fail_o
);
  import pg_mask_pkg::*;

  logic [WIDTH-1:0] fail_next;
  logic level_next;

  generate
    if (WIDTH < 1) begin : g_width_check
      $error("pg_tree needs at least one source");
    end
  endgenerate

  // A source fails only while it is unmasked and not good
  always_comb begin
    fail_next = ~good_i & ~mask_i;
    level_next = ~|fail_next;
  end

  // Level is registered so the pin never glitches between sources
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o <= PG_LEVEL_RESET;
    end else begin
      level_o <= level_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fail_o <= '0;
    end else begin
      fail_o <= fail_next;
    end
  end

endmodule

// ---- tb/pg_mask_bank_properties.sv ----
// Port-level properties of the power-good output mask bank
`timescale 1ns/10ps
module pg_mask_bank_properties
  import pg_mask_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 10,
  parameter int unsigned VARIANT = 0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [5:0] step_down_good_i,
  input wire logic second_adjustable_linear_reg_good_i,
  input wire logic third_adjustable_linear_reg_good_i,
  input wire logic load_switch_a_one_good_i,
  input wire logic load_switch_b_one_good_i,
  input wire logic switch_b_two_good_i,
  input wire logic first_adjustable_linear_reg_good_i,
  input wire logic memory_termination_reg_good_i,
  input wire logic control_input_one_i,
  input wire logic control_input_two_i,
  input wire logic control_input_four_i,
  input wire logic control_input_five_i,
  input wire logic general_output_pin_two_o,
  input wire logic general_output_pin_three_o
);
  logic shared_good;
  logic all_three;
  logic all_two;
  assign shared_good = (VARIANT == VARIANT_SHARED_SWITCH) ? switch_b_two_good_i : first_adjustable_linear_reg_good_i;
  assign all_three = &{second_adjustable_linear_reg_good_i, load_switch_a_one_good_i, step_down_good_i};
  assign all_two = all_three & shared_good & third_adjustable_linear_reg_good_i & load_switch_b_one_good_i &
    memory_termination_reg_good_i & control_input_one_i & control_input_two_i & control_input_four_i &
    control_input_five_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  // Reset is part of the window so the capture stage is live on every counted edge
  sequence good2_s;
    (nrst_i && all_two) [*3];
  endsequence
  sequence good3_s;
    (nrst_i && all_three) [*3];
  endsequence
  AST_READY_AFTER_SETUP: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_READY_IDLE: assert property (!psel_i |=> !pready_o)
    else $error("ready without select");
  AST_ERR_MISALIGNED: assert property (setup_s ##0 (paddr_i[1:0] != 2'b00) |=> pslverr_o)
    else $error("misaligned access not refused");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error outside access");
  AST_UPPER_ZERO: assert property (pready_o && !pwrite_i && paddr_i[9:2] != IDX_STATUS |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_WRITE_RDATA_ZERO: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0)
    else $error("read data on write");
  AST_PIN2_ALL_GOOD: assert property (good2_s |=> general_output_pin_two_o)
    else $error("pin two low with all sources good");
  AST_PIN3_ALL_GOOD: assert property (good3_s |=> general_output_pin_three_o)
    else $error("pin three low with all sources good");
endmodule
bind power_good_output_mask_bank pg_mask_bank_properties #(.ADDR_WIDTH(ADDR_WIDTH), .VARIANT(VARIANT)) i_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .step_down_good_i(step_down_good_i), .second_adjustable_linear_reg_good_i(second_adjustable_linear_reg_good_i),
  .third_adjustable_linear_reg_good_i(third_adjustable_linear_reg_good_i),
  .load_switch_a_one_good_i(load_switch_a_one_good_i), .load_switch_b_one_good_i(load_switch_b_one_good_i),
  .switch_b_two_good_i(switch_b_two_good_i), .first_adjustable_linear_reg_good_i(first_adjustable_linear_reg_good_i),
  .memory_termination_reg_good_i(memory_termination_reg_good_i), .control_input_one_i(control_input_one_i),
  .control_input_two_i(control_input_two_i), .control_input_four_i(control_input_four_i),
  .control_input_five_i(control_input_five_i), .general_output_pin_two_o(general_output_pin_two_o),
  .general_output_pin_three_o(general_output_pin_three_o));

// ---- tb/pg_pin_watcher.sv ----
// Pin sampler standing in for the processor that watches the pins
`timescale 1ns/10ps
module pg_pin_watcher (
  input wire logic core_clk_i,
  input wire logic pin_two_i,
  input wire logic pin_three_i,
  output logic seen_two_o,
  output logic seen_three_o
);
  // One stage, as the processor's input synchroniser adds
  always_ff @(posedge core_clk_i) begin
    seen_two_o <= pin_two_i;
    seen_three_o <= pin_three_i;
  end
endmodule

// ---- tb/test_power_good_output_mask_bank.sv ----
// Testbench for the power-good output mask bank
`timescale 1ns/10ps
module test_power_good_output_mask_bank;
  import pg_mask_pkg::*;
  localparam logic [9:0] REGS [3] = '{{IDX_PIN2_FIRST, 2'b00}, {IDX_PIN2_SECOND, 2'b00}, {IDX_PIN3_FIRST, 2'b00}};
  localparam logic [9:0] BAD [3] = '{10'h2a2, 10'h3fc, {IDX_STATUS, 2'b00}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [15:0] src = 16'hffff;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pin2, pin3, seen2, seen3, er, pin2_v3;
  int n_errors = 0;
  int checked = 0;
  initial forever #12.5 clk = ~clk;
  power_good_output_mask_bank #(.ADDR_WIDTH(10), .VARIANT(0)) i_power_good_output_mask_bank (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .step_down_good_i(src[5:0]), .second_adjustable_linear_reg_good_i(src[7]),
    .third_adjustable_linear_reg_good_i(src[8]), .load_switch_a_one_good_i(src[6]),
    .load_switch_b_one_good_i(src[9]), .switch_b_two_good_i(~src[10]),
    .first_adjustable_linear_reg_good_i(src[10]), .memory_termination_reg_good_i(src[11]),
    .control_input_one_i(src[12]), .control_input_two_i(src[13]), .control_input_four_i(src[14]),
    .control_input_five_i(src[15]), .general_output_pin_two_o(pin2), .general_output_pin_three_o(pin3));
  // Shared-switch variant (VARIANT_SHARED_SWITCH) shares the bus and picks the other shared source
  power_good_output_mask_bank #(.ADDR_WIDTH(10), .VARIANT(VARIANT_SHARED_SWITCH))
    i_power_good_output_mask_bank_v3 (
    .core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(), .pready_o(), .pslverr_o(),
    .step_down_good_i(src[5:0]), .second_adjustable_linear_reg_good_i(src[7]),
    .third_adjustable_linear_reg_good_i(src[8]), .load_switch_a_one_good_i(src[6]),
    .load_switch_b_one_good_i(src[9]), .switch_b_two_good_i(~src[10]),
    .first_adjustable_linear_reg_good_i(src[10]), .memory_termination_reg_good_i(src[11]),
    .control_input_one_i(src[12]), .control_input_two_i(src[13]), .control_input_four_i(src[14]),
    .control_input_five_i(src[15]), .general_output_pin_two_o(pin2_v3), .general_output_pin_three_o());
  pg_pin_watcher i_pg_pin_watcher (.core_clk_i(clk), .pin_two_i(pin2), .pin_three_i(pin3),
    .seen_two_o(seen2), .seen_three_o(seen3));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Idle cycle after each transfer keeps one assignment per signal per step
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) n_errors++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic masks(input logic [15:0] m);
    xfer(1'b1, REGS[0], {24'h0, m[7:0]}, 4'hf);
    xfer(1'b1, REGS[1], {24'h0, m[15:8]}, 4'hf);
    xfer(1'b1, REGS[2], {24'h0, m[7:0]}, 4'hf);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({pin2, pin3}, {PG_LEVEL_RESET, PG_LEVEL_RESET});
    xfer(1'b0, REGS[0], 32'h0, 4'hf);
    chk(rd, {24'h0, PIN2_FIRST_DEFAULT[0]});
    xfer(1'b0, REGS[1], 32'h0, 4'hf);
    chk(rd, {24'h0, PIN2_SECOND_DEFAULT[0]});
    xfer(1'b0, REGS[2], 32'h0, 4'hf);
    chk(rd, {24'h0, PIN3_FIRST_DEFAULT[0]});
    chk({pin2, pin3}, 2'b11);
    $display("test reset_defaults done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, REGS[i], 32'hffff_ff5a, 4'hf);
      xfer(1'b1, REGS[i], 32'h0000_00a5, 4'he);
      chk(er, 1'b0);
      xfer(1'b0, REGS[i], 32'h0, 4'hf);
      chk(rd, 32'h0000_005a);
    end
    $display("test readback done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, BAD[i], 32'h0, 4'hf);
      chk(er, 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, BAD[i], 32'h0, 4'hf);
      chk({er, rd}, {1'b1, 32'h0});
    end
    xfer(1'b0, REGS[0], 32'h0, 4'hf);
    chk(rd, 32'h0000_005a);
    $display("test refusals done");
    masks(16'h0000);
    for (int i = 0; i < 16; i++) begin
      src <= ~(16'h0001 << i);
      repeat (5) @(posedge clk);
      chk(seen2, 1'b0);
      chk(seen3, i >= 8);
      chk(pin2_v3, i == MASK_WIDTH + BIT_SHARED);
      masks(16'h0001 << i);
      repeat (5) @(posedge clk);
      chk({seen2, seen3}, 2'b11);
      masks(16'h0000);
      src <= 16'hffff;
      @(posedge clk);
    end
    $display("test source_masking done");
    tally_and_finish();
  end
endmodule
